/* shared/eeprom_link_pkg.sv */
// constants shared by the two-wire eeprom target and its bus controller
// assumes both ends run on the same 125 MHz core clock
package eeprom_link_pkg;
	localparam int CORE_CLK_MHZ        = 125;
	localparam int WRITE_CYCLE_TIME_MS = 5;
	// longest time; 5 ms at 125 MHz gives exactly 625000 cycles
	localparam int WRITE_CYCLE_CYCLES  = WRITE_CYCLE_TIME_MS * 1000 * CORE_CLK_MHZ;
	localparam int ADDR_W              = 11;
	localparam int PAGE_W              = 4;
	localparam int PAGE_BYTES          = 16;
	localparam int MEM_DEPTH           = 2048;
	localparam int BYTE_BITS           = 8;
	localparam int DEV_RW_BIT          = 0;
	localparam int DEV_PAGE_LSB        = 1;
	localparam int DEV_TYPE_LSB        = 4;
	// arbitrary value; both ends must agree on it
	localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h5;
	// 80 cycles a quarter gives about 390 kHz on the bus
	localparam int SCL_QUARTER_DEFAULT = 80;
	localparam logic [3:0] BYTE_SLOT_LAST    = 4'h8;
	localparam logic [3:0] RECOVER_START2    = 4'ha;
	localparam logic [3:0] RECOVER_SLOT_LAST = 4'hb;
	typedef enum logic [2:0] {OP_START, OP_STOP, OP_WRITE, OP_READ, OP_RECOVER} ctl_op_t;
endpackage : eeprom_link_pkg

/* shared/two_wire_if.sv */
// two-wire bus between the eeprom target and its controller
// open-drain wires with pull-ups; the bench only instantiates this
`timescale 1ns/1ns
interface two_wire_if;
	logic ctlSclOut;
	logic ctlSclOe;
	logic ctlSdaOut;
	logic ctlSdaOe;
	logic tgtSdaOut;
	logic tgtSdaOe;
	logic scl;
	logic sda;

	// a wire is low while any enabled driver pulls it low
	assign scl = ~(ctlSclOe & ~ctlSclOut);
	assign sda = ~((ctlSdaOe & ~ctlSdaOut) | (tgtSdaOe & ~tgtSdaOut));

	modport target (
		input  scl,
		input  sda,
		output tgtSdaOut,
		output tgtSdaOe
	);

	modport controller (
		input  sda,
		output ctlSclOut,
		output ctlSclOe,
		output ctlSdaOut,
		output ctlSdaOe
	);
endinterface : two_wire_if

/* rtl/eeprom_target.sv */
// two-wire serial eeprom target: 2048 bytes, 16-byte pages, timed writes
// bus pins arrive from another domain and are synchronised here
// Notes on behaviour
// RULE_01: data moves only while clock low
// RULE_02: falling data with clock high starts
// RULE_03: rising data with clock high stops
// RULE_04: each byte acknowledged low in ninth clock
// RULE_05: standby at power-up and after stop
// RULE_06: start, nine clocks, start, stop recovers
// RULE_07: device address byte follows each start
// RULE_08: upper four bits match device type
// RULE_09: next three bits are page select
// RULE_10: last address bit chooses read or write
// RULE_11: mismatch gives no acknowledge, back to standby
// RULE_12: byte write: word address, data, stop
// RULE_13: timed write cycle ignores the bus
// RULE_14: page write takes up to sixteen bytes
// RULE_15: write address wraps inside the page
// RULE_16: polling acknowledged only after write ends
// RULE_17: counter holds last address plus one
// RULE_18: read address wraps over whole array
// RULE_19: current read sends byte at counter
// RULE_20: random read: dummy write, repeated start
// RULE_21: controller acknowledge continues sequential read
// RULE_22: 128 pages of 16, 11-bit address
// RULE_23: write protect high blocks all writes
// RULE_24: sample on rise, drive after fall, low only
`timescale 1ns/1ns
module eeprom_target #(
	parameter logic [3:0] DEVICE_TYPE  = eeprom_link_pkg::DEVICE_TYPE_DEFAULT,
	parameter int         WRITE_CYCLES = eeprom_link_pkg::WRITE_CYCLE_CYCLES
) (
	input  wire logic  core_clk,
	input  wire logic  rst,
	two_wire_if.target link,
	input  wire logic  writeProtect,
	output logic       writeBusy,
	output logic       standby
);
	localparam int AW = eeprom_link_pkg::ADDR_W;
	localparam int PW = eeprom_link_pkg::PAGE_W;
	localparam int PB = eeprom_link_pkg::PAGE_BYTES;
	localparam int MD = eeprom_link_pkg::MEM_DEPTH;
	localparam int TL = eeprom_link_pkg::DEV_TYPE_LSB;
	localparam int PL = eeprom_link_pkg::DEV_PAGE_LSB;
	localparam int RW = eeprom_link_pkg::DEV_RW_BIT;
	localparam logic [3:0]  BYTE_DONE  = eeprom_link_pkg::BYTE_SLOT_LAST;
	localparam logic [19:0] TIMER_LAST = 20'(WRITE_CYCLES - 1);

	typedef enum logic [2:0] {T_IDLE, T_RX, T_RX_ACK, T_TX, T_TX_ACK} tgt_fsm_t;
	typedef enum logic [1:0] {RX_DEV, RX_WORD, RX_DATA} rx_phase_t;

	typedef struct packed {
		logic                 sclS1;
		logic                 sclS2;
		logic                 sclPrev;
		logic                 sdaS1;
		logic                 sdaS2;
		logic                 sdaPrev;
		logic                 wpS1;
		logic                 wpS2;
		tgt_fsm_t             st;
		rx_phase_t            phase;
		logic                 readDir;
		logic [3:0]           bitCnt;
		logic [7:0]           shift;
		logic                 hostAck;
		logic                 sdaLow;
		logic [AW-1:0]        addr;
		logic [PB-1:0][7:0]   pageBuf;
		logic [PB-1:0]        pageMask;
		logic [AW-PW-1:0]     commitPage;
		logic                 busy;
		logic [19:0]          timer;
		logic [MD-1:0][7:0]   mem;
	} tgt_t;

	tgt_t r;
	tgt_t next_r;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	// edges seen on the synchronised copies only
	assign sclRise   = r.sclS2 & ~r.sclPrev;
	assign sclFall   = ~r.sclS2 & r.sclPrev;
	assign startSeen = r.sclS2 & r.sclPrev & r.sdaPrev & ~r.sdaS2; // [RULE_01] [RULE_02]
	assign stopSeen  = r.sclS2 & r.sclPrev & ~r.sdaPrev & r.sdaS2; // [RULE_01] [RULE_03]

	// puts the byte at the counter on the wire, counter moves on by one
	function automatic tgt_t loadByte(input tgt_t s);
		tgt_t t;
		t        = s;
		t.st     = T_TX;
		t.shift  = {s.mem[s.addr][6:0], 1'b0};
		t.sdaLow = ~s.mem[s.addr][7]; // [RULE_19] [RULE_24]
		t.bitCnt = 4'h1;
		t.addr   = s.addr + 11'h001; // [RULE_17] [RULE_18]
		return t;
	endfunction : loadByte

	always_comb
	begin
		next_r         = r;
		next_r.sclS1   = link.scl;
		next_r.sclS2   = r.sclS1;
		next_r.sclPrev = r.sclS2;
		next_r.sdaS1   = link.sda;
		next_r.sdaS2   = r.sdaS1;
		next_r.sdaPrev = r.sdaS2;
		next_r.wpS1    = writeProtect;
		next_r.wpS2    = r.wpS1;
		if (r.busy)
		begin
			// bus is deaf here, so polling sees no acknowledge
			next_r.st     = T_IDLE; // [RULE_13] [RULE_16]
			next_r.sdaLow = 1'b0;
			if (r.timer == TIMER_LAST)
			begin
				next_r.busy     = 1'b0;
				next_r.timer    = '0;
				next_r.pageMask = '0;
				for (int i = 0; i < PB; i++)
				begin
					if (r.pageMask[i])
					begin
						next_r.mem[{r.commitPage, PW'(i)}] = r.pageBuf[i]; // [RULE_14]
					end
				end
			end
			else
			begin
				next_r.timer = r.timer + 20'h00001; // [RULE_13]
			end
		end
		else if (startSeen)
		begin
			// honoured in every state outside the write cycle; an unfinished write is dropped
			next_r.st       = T_RX; // [RULE_02] [RULE_06] [RULE_07]
			next_r.phase    = RX_DEV;
			next_r.bitCnt   = '0;
			next_r.sdaLow   = 1'b0;
			next_r.pageMask = '0; // [RULE_20]
		end
		else if (stopSeen)
		begin
			next_r.st     = T_IDLE; // [RULE_03] [RULE_06]
			next_r.sdaLow = 1'b0;
			if (|r.pageMask && !r.wpS2)
			begin
				next_r.busy       = 1'b1; // [RULE_12] [RULE_13]
				next_r.commitPage = r.addr[AW-1:PW];
			end
			else
			begin
				next_r.pageMask = '0; // [RULE_23]
			end
		end
		else
		begin
			unique case (r.st)
				T_IDLE:
				begin
				end
				T_RX:
				begin
					if (sclRise)
					begin
						next_r.shift  = {r.shift[6:0], r.sdaS2}; // [RULE_24]
						next_r.bitCnt = r.bitCnt + 4'h1;
					end
					else if (sclFall && r.bitCnt == BYTE_DONE)
					begin
						next_r.bitCnt = '0;
						next_r.st     = T_RX_ACK;
						next_r.sdaLow = 1'b1; // [RULE_04]
						unique case (r.phase)
							RX_DEV:
							begin
								if (r.shift[7:TL] == DEVICE_TYPE) // [RULE_08]
								begin
									next_r.readDir = r.shift[RW]; // [RULE_10]
									if (!r.shift[RW])
									begin
										next_r.addr[AW-1:BYTE_DONE] = r.shift[TL-1:PL]; // [RULE_09]
									end
								end
								else
								begin
									next_r.st     = T_IDLE; // [RULE_11]
									next_r.sdaLow = 1'b0;
								end
							end
							RX_WORD:
							begin
								next_r.addr = {r.addr[AW-1:BYTE_DONE], r.shift}; // [RULE_12] [RULE_22]
							end
							RX_DATA:
							begin
								next_r.pageBuf[r.addr[PW-1:0]]  = r.shift; // [RULE_14]
								next_r.pageMask[r.addr[PW-1:0]] = 1'b1;
								next_r.addr[PW-1:0] = r.addr[PW-1:0] + 4'h1; // [RULE_15]
							end
							default:
							begin
								next_r.st     = T_IDLE;
								next_r.sdaLow = 1'b0;
							end
						endcase
					end
				end
				T_RX_ACK:
				begin
					if (sclFall)
					begin
						next_r.sdaLow = 1'b0;
						if (r.phase == RX_DEV && r.readDir)
						begin
							next_r = loadByte(next_r); // [RULE_19]
						end
						else
						begin
							next_r.st    = T_RX;
							next_r.phase = (r.phase == RX_DEV) ? RX_WORD : RX_DATA; // [RULE_12]
						end
					end
				end
				T_TX:
				begin
					if (sclFall)
					begin
						if (r.bitCnt == BYTE_DONE)
						begin
							next_r.sdaLow  = 1'b0;
							next_r.hostAck = 1'b0;
							next_r.st      = T_TX_ACK;
						end
						else
						begin
							next_r.sdaLow = ~r.shift[7]; // [RULE_24]
							next_r.shift  = {r.shift[6:0], 1'b0};
							next_r.bitCnt = r.bitCnt + 4'h1;
						end
					end
				end
				T_TX_ACK:
				begin
					if (sclRise)
					begin
						next_r.hostAck = ~r.sdaS2;
					end
					else if (sclFall)
					begin
						if (r.hostAck)
						begin
							next_r = loadByte(next_r); // [RULE_21]
						end
						else
						begin
							next_r.st = T_IDLE; // [RULE_21]
						end
					end
				end
				default:
				begin
					next_r.st     = T_IDLE;
					next_r.sdaLow = 1'b0;
				end
			endcase
		end
		if (rst)
		begin
			// array clears too; power-up contents are left undefined otherwise
			next_r         = '0; // [RULE_05]
			next_r.sclS1   = 1'b1;
			next_r.sclS2   = 1'b1;
			next_r.sclPrev = 1'b1;
			next_r.sdaS1   = 1'b1;
			next_r.sdaS2   = 1'b1;
			next_r.sdaPrev = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		r <= next_r;
	end

	assign link.tgtSdaOut = 1'b0; // [RULE_24]
	assign link.tgtSdaOe  = r.sdaLow;
	assign writeBusy      = r.busy;
	assign standby        = (r.st == T_IDLE) & ~r.busy; // [RULE_03] [RULE_05]
endmodule : eeprom_target

/* rtl/eeprom_controller.sv */
// byte-level two-wire bus controller for the eeprom target
// makes the bus clock by dividing core_clk; no clock stretching
`timescale 1ns/1ns
module eeprom_controller #(
	parameter int QUARTER = eeprom_link_pkg::SCL_QUARTER_DEFAULT
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	two_wire_if.controller                link,
	input  wire logic                     cmdValid,
	output logic                          cmdReady,
	input  wire eeprom_link_pkg::ctl_op_t cmdOp,
	input  wire logic [7:0]               cmdData,
	input  wire logic                     cmdAck,
	output logic                          rspValid,
	output logic [7:0]                    rspData,
	output logic                          rspNack
);
	localparam logic [15:0] Q_LAST = 16'(QUARTER - 1);
	localparam logic [3:0]  B_LAST = eeprom_link_pkg::BYTE_SLOT_LAST;

	typedef enum logic [1:0] {SL_START, SL_BIT, SL_STOP} slot_t;

	typedef struct packed {
		logic                     sdaS1;
		logic                     sdaS2;
		logic                     busy;
		eeprom_link_pkg::ctl_op_t op;
		logic [15:0]              cnt;
		logic [1:0]               phase;
		logic [3:0]               slot;
		logic [8:0]               bits;
		logic [7:0]               rx;
		logic                     sclLow;
		logic                     sdaLow;
		logic                     rspValid;
		logic [7:0]               rspData;
		logic                     rspNack;
	} ctl_t;

	ctl_t  r;
	ctl_t  next_r;
	slot_t kind;
	logic  lastSlot;

	always_comb
	begin
		kind     = SL_BIT;
		lastSlot = (r.slot == B_LAST);
		unique case (r.op)
			eeprom_link_pkg::OP_START:
			begin
				kind     = SL_START;
				lastSlot = 1'b1;
			end
			eeprom_link_pkg::OP_STOP:
			begin
				kind     = SL_STOP;
				lastSlot = 1'b1;
			end
			eeprom_link_pkg::OP_RECOVER:
			begin
				// start, nine released clocks, start, stop
				lastSlot = (r.slot == eeprom_link_pkg::RECOVER_SLOT_LAST); // [RULE_06]
				if (r.slot == '0 || r.slot == eeprom_link_pkg::RECOVER_START2)
				begin
					kind = SL_START;
				end
				else if (lastSlot)
				begin
					kind = SL_STOP;
				end
			end
			default:
			begin
			end
		endcase
	end

	always_comb
	begin
		next_r          = r;
		next_r.sdaS1    = link.sda;
		next_r.sdaS2    = r.sdaS1;
		next_r.rspValid = 1'b0;
		if (!r.busy)
		begin
			if (cmdValid)
			begin
				// sequencing of address, data and stop is the user's job
				next_r.busy  = 1'b1; // [RULE_07] [RULE_12] [RULE_14] [RULE_20]
				next_r.op    = cmdOp;
				next_r.cnt   = '0;
				next_r.phase = '0;
				next_r.slot  = '0;
				next_r.bits  = 9'h1ff;
				if (cmdOp == eeprom_link_pkg::OP_WRITE)
				begin
					next_r.bits = {cmdData, 1'b1};
				end
				else if (cmdOp == eeprom_link_pkg::OP_READ)
				begin
					next_r.bits = {8'hff, ~cmdAck}; // [RULE_19] [RULE_21]
				end
			end
		end
		else if (r.cnt != Q_LAST)
		begin
			next_r.cnt = r.cnt + 16'h0001;
		end
		else
		begin
			next_r.cnt   = '0;
			next_r.phase = r.phase + 2'h1;
			unique case (kind)
				SL_START:
				begin
					unique case (r.phase)
						2'h0: next_r.sdaLow = 1'b0;
						2'h1: next_r.sclLow = 1'b0;
						2'h2: next_r.sdaLow = 1'b1; // [RULE_02]
						2'h3: next_r.sclLow = 1'b1;
					endcase
				end
				SL_STOP:
				begin
					unique case (r.phase)
						2'h0: next_r.sdaLow = 1'b1;
						2'h1: next_r.sclLow = 1'b0;
						2'h2: next_r.sdaLow = 1'b0; // [RULE_03]
						2'h3: next_r.sclLow = 1'b0;
					endcase
				end
				default:
				begin
					unique case (r.phase)
						2'h0:
						begin
							next_r.sclLow = 1'b1;
							next_r.sdaLow = ~r.bits[8]; // [RULE_01]
						end
						2'h1: next_r.sclLow = 1'b0;
						2'h2:
						begin
							if (r.slot == B_LAST)
							begin
								next_r.rspNack = r.sdaS2;
							end
							else
							begin
								next_r.rx = {r.rx[6:0], r.sdaS2};
							end
						end
						2'h3:
						begin
							next_r.sclLow = 1'b1;
							next_r.bits   = {r.bits[7:0], 1'b1};
						end
					endcase
				end
			endcase
			if (r.phase == 2'h3)
			begin
				next_r.slot = r.slot + 4'h1;
				if (lastSlot)
				begin
					next_r.busy = 1'b0;
					if (r.op == eeprom_link_pkg::OP_WRITE || r.op == eeprom_link_pkg::OP_READ)
					begin
						next_r.rspValid = 1'b1;
						next_r.rspData  = r.rx;
					end
				end
			end
		end
		if (rst)
		begin
			next_r       = '0;
			next_r.sdaS1 = 1'b1;
			next_r.sdaS2 = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		r <= next_r;
	end

	assign cmdReady       = ~r.busy;
	assign link.ctlSclOut = 1'b0;
	assign link.ctlSclOe  = r.sclLow;
	assign link.ctlSdaOut = 1'b0;
	assign link.ctlSdaOe  = r.sdaLow;
	assign rspValid       = r.rspValid;
	assign rspData        = r.rspData;
	assign rspNack        = r.rspNack;
endmodule : eeprom_controller

/* sim/eeprom_link_sva.sv */
// checker for the two-wire link between controller and eeprom target
// sees only the interface wires; one core clock domain, sync reset
`timescale 1ns/1ns
module eeprom_link_sva #(
	parameter int QUARTER = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ctlSclOut,
	input wire logic ctlSclOe,
	input wire logic ctlSdaOut,
	input wire logic ctlSdaOe,
	input wire logic tgtSdaOut,
	input wire logic tgtSdaOe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	int holdCnt;

	// ack plus eight zero bits is the longest legal pull
	always_ff @(posedge core_clk)
	begin
		if (rst || !tgtSdaOe)
			holdCnt <= 0;
		else
			holdCnt <= holdCnt + 1;
	end

	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence

	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	tgt_low_only_a: assert property (tgtSdaOe |-> !tgtSdaOut)
		else $error("target drives sda high");
	ctl_low_only_a: assert property ((ctlSdaOe || ctlSclOe) |-> !(ctlSdaOut || ctlSclOut))
		else $error("controller drives a wire high");
	tgt_steady_high_a: assert property (scl && $past(scl) |-> $stable(tgtSdaOe))
		else $error("target changed sda while scl high");
	no_contention_a: assert property (tgtSdaOe && scl |-> !ctlSdaOe)
		else $error("both ends pull sda in one bit");
	scl_low_span_a: assert property ($fell(scl) |-> (!scl)[*8])
		else $error("scl low phase too short");
	scl_high_span_a: assert property ($rose(scl) |-> scl[*8])
		else $error("scl high phase too short");
	stop_release_a: assert property (s_stop |-> (!tgtSdaOe)[*8])
		else $error("target pulls sda after stop");
	start_release_a: assert property (s_start |-> (!tgtSdaOe)[*8])
		else $error("target pulls sda after start");
	ack_span_a: assert property (holdCnt < 9 * 4 * QUARTER + 8)
		else $error("target holds sda low too long");
endmodule : eeprom_link_sva

/* sim/test_two_wire_serial_eeprom_target.sv */
// self-checking bench: controller and eeprom target on one two-wire link
// both ends share core_clk; the bench drives the controller command port
`timescale 1ns/1ns
module test_two_wire_serial_eeprom_target;
	localparam int         WCYC = 2000;
	localparam int         QTR  = 8;
	localparam logic [3:0] DT   = eeprom_link_pkg::DEVICE_TYPE_DEFAULT;

	logic                     core_clk;
	logic                     rst;
	logic                     writeProtect;
	logic                     writeBusy;
	logic                     standby;
	logic                     cmdValid;
	logic                     cmdReady;
	eeprom_link_pkg::ctl_op_t cmdOp;
	logic [7:0]               cmdData;
	logic                     cmdAck;
	logic                     rspValid;
	logic [7:0]               rspData;
	logic                     rspNack;
	int                       errorCnt;
	int                       nCompared;
	int                       p;
	integer                   seed;
	logic [7:0]               mem [2048];
	logic [10:0]              ctr;
	logic [10:0]              base;
	logic                     nack;
	logic [7:0]               rd;

	two_wire_if link ();

	eeprom_target #(.WRITE_CYCLES(WCYC)) i_eeprom_target (
		.core_clk     (core_clk),
		.rst          (rst),
		.link         (link),
		.writeProtect (writeProtect),
		.writeBusy    (writeBusy),
		.standby      (standby)
	);

	eeprom_controller #(.QUARTER(QTR)) i_eeprom_controller (
		.core_clk (core_clk),
		.rst      (rst),
		.link     (link),
		.cmdValid (cmdValid),
		.cmdReady (cmdReady),
		.cmdOp    (cmdOp),
		.cmdData  (cmdData),
		.cmdAck   (cmdAck),
		.rspValid (rspValid),
		.rspData  (rspData),
		.rspNack  (rspNack)
	);

	eeprom_link_sva #(.QUARTER(QTR)) i_eeprom_link_sva (
		.core_clk  (core_clk),
		.rst       (rst),
		.ctlSclOut (link.ctlSclOut),
		.ctlSclOe  (link.ctlSclOe),
		.ctlSdaOut (link.ctlSdaOut),
		.ctlSdaOe  (link.ctlSdaOe),
		.tgtSdaOut (link.tgtSdaOut),
		.tgtSdaOe  (link.tgtSdaOe),
		.scl       (link.scl),
		.sda       (link.sda)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one command; returns 1 ns after the edge at which the controller is ready again
	// ready is only looked at 1 ns after an edge, never in the edge's own time step
	task automatic xfer(input eeprom_link_pkg::ctl_op_t op, input logic [7:0] d, input logic a);
		int n;
		n = 0;
		cmdOp = op;
		cmdData = d;
		cmdAck = a;
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1 && n < 1000)
		begin
			@(posedge core_clk);
			#1 n++;
		end
		@(posedge core_clk);
		#1 cmdValid = 1'b0;
		while (cmdReady !== 1'b1 && n < 1000)
		begin
			@(posedge core_clk);
			#1 n++;
		end
		// a controller that never comes back is a failure, not a silent pass
		if (n >= 1000)
		begin
			errorCnt++;
			reportAndStop();
		end
		nack = rspNack;
		rd = rspData;
		check("response valid", 16'(rspValid),
			16'(op == eeprom_link_pkg::OP_WRITE || op == eeprom_link_pkg::OP_READ));
	endtask : xfer

	task automatic dev(input logic [2:0] pg, input logic rw);
		xfer(eeprom_link_pkg::OP_START, 8'h00, 1'b0);
		xfer(eeprom_link_pkg::OP_WRITE, {DT, pg, rw}, 1'b0);
	endtask : dev

	task automatic stop();
		xfer(eeprom_link_pkg::OP_STOP, 8'h00, 1'b0);
	endtask : stop

	task automatic wrpage(input logic [10:0] a, input int cnt);
		logic [7:0] d;
		dev(a[10:8], 1'b0);
		check("write device ack", nack, 1'b0);
		xfer(eeprom_link_pkg::OP_WRITE, a[7:0], 1'b0);
		check("word address ack", nack, 1'b0);
		for (int i = 0; i < cnt; i++)
		begin
			d = 8'($random(seed));
			xfer(eeprom_link_pkg::OP_WRITE, d, 1'b0);
			check("data ack", nack, 1'b0);
			if (!writeProtect)
				mem[a] = d;
			a = {a[10:4], a[3:0] + 4'h1};
		end
		stop();
	endtask : wrpage

	// polling while the write cycle runs must be refused at first
	task automatic poll(input logic [2:0] pg);
		p = 0;
		do
		begin
			dev(pg, 1'b0);
			p++;
		end
		while (nack && p < 40);
		check("polls refused", 16'(p > 1), 1'b1);
		check("poll acked", nack, 1'b0);
	endtask : poll

	task automatic rdseq(input int cnt);
		for (int i = 0; i < cnt; i++)
		begin
			xfer(eeprom_link_pkg::OP_READ, 8'h00, 16'(i) < 16'(cnt - 1));
			check("read data", rd, mem[ctr]);
			ctr = ctr + 11'h001;
		end
		stop();
		check("standby after read", standby, 1'b1);
	endtask : rdseq

	task automatic rnd(input logic [10:0] a, input int cnt);
		dev(a[10:8], 1'b0);
		xfer(eeprom_link_pkg::OP_WRITE, a[7:0], 1'b0);
		dev(3'($random(seed)), 1'b1);
		check("read device ack", nack, 1'b0);
		ctr = a;
		rdseq(cnt);
	endtask : rnd

	task automatic reportAndStop();
		if (errorCnt == 0 && nCompared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : reportAndStop

	initial
	begin
		#700000;
		errorCnt++;
		reportAndStop();
	end

	initial
	begin
		seed = 32'h3396;
		rst = 1'b1;
		writeProtect = 1'b0;
		cmdValid = 1'b0;
		cmdOp = eeprom_link_pkg::OP_START;
		cmdData = 8'h00;
		cmdAck = 1'b0;
		errorCnt = 0;
		nCompared = 0;
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (12) @(posedge core_clk);
		#1 rst = 1'b0;
		check("standby after reset", standby, 1'b1);
		// type code off by one bit only
		xfer(eeprom_link_pkg::OP_START, 8'h00, 1'b0);
		xfer(eeprom_link_pkg::OP_WRITE, {DT ^ 4'h1, 3'h2, 1'b0}, 1'b0);
		check("foreign type nack", nack, 1'b1);
		stop();
		check("standby after nack", standby, 1'b1);
		// 18 bytes from offset d wrap and overwrite within the page
		base = {11'($random(seed)) & 11'h7f0};
		wrpage(base | 11'h00d, 18);
		check("busy after stop", writeBusy, 1'b1);
		check("no standby while busy", standby, 1'b0);
		poll(base[10:8]);
		xfer(eeprom_link_pkg::OP_WRITE, base[7:0], 1'b0);
		dev(3'h0, 1'b1);
		ctr = base;
		rdseq(16);
		rnd(11'h7fe, 4);
		dev(3'($random(seed)), 1'b1);
		check("current read ack", nack, 1'b0);
		rdseq(1);
		for (int k = 0; k < 2; k++)
		begin
			wrpage(11'($random(seed)), 1);
			poll(3'h0);
			stop();
		end
		writeProtect = 1'b1;
		repeat (4) @(posedge core_clk);
		#1 wrpage(base, 2);
		check("no write cycle", writeBusy, 1'b0);
		writeProtect = 1'b0;
		rnd(base, 2);
		// interrupted write, then the recovery sequence
		dev(base[10:8], 1'b0);
		xfer(eeprom_link_pkg::OP_WRITE, base[7:0], 1'b0);
		xfer(eeprom_link_pkg::OP_RECOVER, 8'h00, 1'b0);
		check("standby after recovery", standby, 1'b1);
		rnd(base + 11'h005, 3);
		reportAndStop();
	end
endmodule : test_two_wire_serial_eeprom_target
